/* File: adc_board_output_glue.sv */
// Baud divider, serial framer, decimation counter and calibration control
`timescale 1ns/1ps

// What this block does
// - Async word: two 11-bit characters, two stops
// - Baud divider divides by 2**n, n 8..12
// - Divider source: master clock or oscillator
// - Shift clock from remote or board baud
// - Word ready drives the CTS output
// - Word ready falls only once previous word emptied
// - Ready tied to select outputs every word unless the decimator is routed
// - Decimator counts 2**(n+1) words, n 0..11
// - Routed counter output drives chip select low
// - Flag arms on select, clears on ready rise
// - Counter resumes counting after clear, repeating
// - Trigger starts calibration of selected kind
// - Unipolar code saturates to ones or zeros
// - Bipolar code saturates beyond either reference
// - Word shift starts only while select low, then runs to the last bit
module adc_board_output_glue (
    input  wire logic                   ref_clk,
    input  wire logic                   reset,
    input  wire logic                   master_clock_in,
    input  wire logic                   osc_clock_in,
    input  wire logic                   remote_shift_clock_in,
    input  wire logic                   remote_select_n,
    input  wire logic                   cal_trigger,
    input  wire logic                   trim_select_a,
    input  wire logic                   trim_select_b,
    input  wire logic                   input_polarity_sel,
    input  wire logic                   async_char_mode,
    input  wire logic                   decimator_route,
    input  wire logic                   board_baud_route,
    input  wire logic                   ready_to_select_tie,
    input  wire logic                   master_clock_sel,
    input  wire logic [3:0]             baud_exp,
    input  wire logic [3:0]             decim_exp,
    input  wire logic                   new_word_stb,
    input  wire logic signed [17:0]     sample_raw,
    output logic                        shift_clock_out,
    output logic                        serial_out_line,
    output logic                        word_ready_n,
    output logic                        cts_out,
    output logic                        decimated_select_n,
    output logic                        chip_select_n,
    output logic                        decim_flag,
    output adc_glue_pkg::cal_req_s      cal_out
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: a level counts once stages two and three agree
    localparam int PW = adc_glue_pkg::PIN_COUNT;

    logic [PW-1:0] pin_raw;
    logic [PW-1:0] sync1;
    logic [PW-1:0] sync2;
    logic [PW-1:0] sync3;
    logic [PW-1:0] pin_q;
    logic [PW-1:0] pin_prev;

    assign pin_raw = {trim_select_b, trim_select_a, cal_trigger, remote_select_n,
                      remote_shift_clock_in, osc_clock_in, master_clock_in};

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pin_q    <= 7'h08;
            pin_prev <= 7'h08;
        end else begin
            for (int i = 0; i < PW; i++) begin
                if (sync2[i] == sync3[i]) begin
                    pin_q[i] <= sync3[i];
                end
            end
            pin_prev <= pin_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Baud divider
    logic [3:0]                              baud_exp_eff;
    logic                                    div_src;
    logic                                    div_src_prev;
    logic [adc_glue_pkg::DIV_CNT_BITS-1:0]   div_cnt;
    logic                                    baud_level;
    // Out-of-range selections clamp instead of leaving the output dead
    assign baud_exp_eff = (baud_exp < adc_glue_pkg::DIV_EXP_MIN) ? adc_glue_pkg::DIV_EXP_MIN
                        : (baud_exp > adc_glue_pkg::DIV_EXP_MAX) ? adc_glue_pkg::DIV_EXP_MAX
                        : baud_exp;
    assign div_src    = master_clock_sel ? pin_q[0] : pin_q[1];
    assign baud_level = div_cnt[baud_exp_eff - 4'h1];

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            div_src_prev <= 1'b0;
            div_cnt      <= '0;
        end else begin
            div_src_prev <= div_src;
            if (div_src && !div_src_prev) begin
                div_cnt <= div_cnt + 12'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shift clock route
    logic shift_prev;
    logic shift_edge;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            shift_clock_out <= 1'b0;
            shift_prev      <= 1'b0;
        end else begin
            shift_clock_out <= board_baud_route ? baud_level : pin_q[2];
            shift_prev      <= shift_clock_out;
        end
    end

    assign shift_edge = shift_clock_out && !shift_prev;
    ////////////////////////////////////////////////////////////////////////
    // Output code with range saturation
    function automatic logic [15:0] sat_code(input logic signed [17:0] raw, input logic bipolar);
        logic signed [18:0] v;
        v = bipolar ? (19'(raw) + signed'(adc_glue_pkg::BIPOLAR_SHIFT)) : 19'(raw);
        if (v < 0) begin
            sat_code = adc_glue_pkg::CODE_ZERO;
        end else if (v > 19'sh0FFFF) begin
            sat_code = adc_glue_pkg::CODE_FULL;
        end else begin
            sat_code = v[15:0];
        end
    endfunction : sat_code

    ////////////////////////////////////////////////////////////////////////
    // Output word and serial framer
    logic [15:0]                           word;
    logic                                  busy;
    logic                                  done;
    logic [adc_glue_pkg::FRAME_BITS-1:0]   frame;
    logic [adc_glue_pkg::FRAME_BITS-1:0]   shreg;
    logic [4:0]                            bits_left;
    logic [15:0]                           word_rev;

    assign word_rev = {<<{word}};
    // First character carries the high byte; characters go LSB first
    assign frame = async_char_mode
        ? {2'b11, word[7:0], 1'b0, 2'b11, word[15:8], 1'b0}
        : {6'h00, word_rev};
    assign done  = busy && shift_edge && (bits_left == 5'h00);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            busy            <= 1'b0;
            shreg           <= '0;
            bits_left       <= 5'h00;
            serial_out_line <= 1'b1;
        end else if (shift_edge) begin
            if (!busy && !word_ready_n && !chip_select_n) begin
                busy            <= 1'b1;
                serial_out_line <= frame[0];
                shreg           <= frame >> 1;
                bits_left       <= async_char_mode ? adc_glue_pkg::FRAME_LAST_ASYNC
                                                   : adc_glue_pkg::FRAME_LAST_SYNC;
            end else if (busy) begin
                if (bits_left == 5'h00) begin
                    busy            <= 1'b0;
                    serial_out_line <= 1'b1;
                end else begin
                    serial_out_line <= shreg[0];
                    shreg           <= shreg >> 1;
                    bits_left       <= bits_left - 5'h01;
                end
            end
        end
    end

    // A word that arrives while the last is still pending is dropped
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            word_ready_n <= 1'b1;
            word         <= adc_glue_pkg::CODE_ZERO;
        end else if (done) begin
            word_ready_n <= 1'b1;
        end else if (new_word_stb && word_ready_n && !busy) begin
            word_ready_n <= 1'b0;
            word         <= sat_code(sample_raw, input_polarity_sel);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cts_out <= 1'b1;
        end else begin
            cts_out <= word_ready_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decimation counter
    logic [3:0]                              decim_eff;
    logic [adc_glue_pkg::DEC_CNT_BITS-1:0]   dec_cnt;
    logic                                    wr_prev;
    logic                                    wr_rise;
    logic                                    wr_fall;

    assign decim_eff          = (decim_exp > adc_glue_pkg::DEC_EXP_MAX) ? adc_glue_pkg::DEC_EXP_MAX : decim_exp;
    assign decimated_select_n = ~dec_cnt[decim_eff + 4'h1];
    assign wr_rise            = word_ready_n && !wr_prev;
    assign wr_fall            = !word_ready_n && wr_prev;
    assign chip_select_n      = decimator_route     ? decimated_select_n
                              : ready_to_select_tie ? word_ready_n
                              : pin_q[3];

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_prev <= 1'b1;
        end else begin
            wr_prev <= word_ready_n;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            decim_flag <= 1'b0;
        end else if (decim_flag && wr_rise) begin
            decim_flag <= 1'b0;
        end else if (!decimated_select_n) begin
            decim_flag <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dec_cnt <= '0;
        end else if (decim_flag && wr_rise) begin
            dec_cnt <= '0;
        end else if (!decim_flag && wr_fall) begin
            dec_cnt <= dec_cnt + 13'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Calibration trigger
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cal_out <= '{start: 1'b0, kind: adc_glue_pkg::CAL_SELF};
        end else begin
            cal_out.start <= pin_q[4] && !pin_prev[4];
            if (pin_q[4] && !pin_prev[4]) begin
                case ({pin_q[5], pin_q[6]})
                    2'b00:   cal_out.kind <= adc_glue_pkg::CAL_SELF;
                    2'b11:   cal_out.kind <= adc_glue_pkg::CAL_SYS_OFFSET_STEP1;
                    2'b01:   cal_out.kind <= adc_glue_pkg::CAL_SYS_GAIN_STEP2;
                    default: cal_out.kind <= adc_glue_pkg::CAL_SYS_OFFSET_ONE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking check_clk @(posedge ref_clk); endclocking
    default disable iff (reset);
    start_bit_low_a: assert property ($rose(busy) |-> !serial_out_line)
        else $error("frame did not open with a start bit");
    div_range_a: assert property (baud_exp_eff >= adc_glue_pkg::DIV_EXP_MIN
        && baud_exp_eff <= adc_glue_pkg::DIV_EXP_MAX) else $error("baud exponent out of range");
    div_count_a: assert property (div_src && !div_src_prev |=> div_cnt == $past(div_cnt) + 12'h001)
        else $error("divider missed a source edge");
    baud_route_a: assert property (board_baud_route && !$past(reset)
        |=> shift_clock_out == $past(baud_level)) else $error("shift clock not taken from baud divider");
    cts_follow_a: assert property ($fell(word_ready_n) |=> !cts_out)
        else $error("cts did not follow word ready");
    ready_held_a: assert property ($fell(word_ready_n) |-> !$past(busy))
        else $error("word ready fell while shifting");
    shift_select_a: assert property ($rose(busy) |-> !$past(chip_select_n))
        else $error("shift started without chip select");
    dec_clear_a: assert property (decim_flag && wr_rise |=> dec_cnt == '0 && !decim_flag)
        else $error("decimator not cleared on ready rise");
    dec_count_a: assert property (!decim_flag && wr_fall |=> dec_cnt == $past(dec_cnt) + 13'h0001)
        else $error("decimator missed a word");
    cal_pulse_a: assert property (cal_out.start |=> !cal_out.start)
        else $error("calibration start longer than one cycle");
endmodule : adc_board_output_glue

/* File: adc_board_output_glue_test.sv */
// Self-checking bench for the converter output glue logic
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module adc_board_output_glue_test;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic master_clock_in = 1'b0;
    logic osc_clock_in = 1'b0;
    logic remote_shift_clock_in, remote_select_n, cal_trigger, trim_select_a, trim_select_b;
    logic input_polarity_sel, async_char_mode, decimator_route, board_baud_route;
    logic ready_to_select_tie, master_clock_sel, new_word_stb;
    logic [3:0] baud_exp, decim_exp;
    logic signed [17:0] sample_raw, raw;
    logic shift_clock_out, serial_out_line, word_ready_n, cts_out, decimated_select_n, chip_select_n, decim_flag;
    adc_glue_pkg::cal_req_s cal_out;
    int num_errors = 0;
    int checks = 0;
    int pulses;
    integer seed = 32'hBADEB869;
    logic [1:0] kind;
    realtime t0;
    logic [21:0] expect_q[$];
    logic signed [17:0] edge_raw[4] = '{18'h1FFFF, 18'h1FFFF, 18'h3FFFF, 18'h20000};
    logic [4:0] baud_cfg[4] = '{5'h18, 5'h19, 5'h08, 5'h17};
    int baud_period[4] = '{5120, 10240, 10240, 5120};
    adc_glue_pkg::cal_kind_e cal_kind[4] = '{adc_glue_pkg::CAL_SELF, adc_glue_pkg::CAL_SYS_GAIN_STEP2,
                                            adc_glue_pkg::CAL_SYS_OFFSET_ONE, adc_glue_pkg::CAL_SYS_OFFSET_STEP1};

    always #2.5 ref_clk = ~ref_clk;
    // Off-grid phase so the synchronisers never see a tie with ref_clk
    initial begin #1.1; forever #10 master_clock_in = ~master_clock_in; end
    initial begin #1.7; forever #20 osc_clock_in = ~osc_clock_in; end

    adc_board_output_glue adc_board_output_glue_inst (.ref_clk(ref_clk), .reset(reset),
        .master_clock_in(master_clock_in), .osc_clock_in(osc_clock_in),
        .remote_shift_clock_in(remote_shift_clock_in), .remote_select_n(remote_select_n),
        .cal_trigger(cal_trigger), .trim_select_a(trim_select_a), .trim_select_b(trim_select_b),
        .input_polarity_sel(input_polarity_sel), .async_char_mode(async_char_mode),
        .decimator_route(decimator_route), .board_baud_route(board_baud_route),
        .ready_to_select_tie(ready_to_select_tie), .master_clock_sel(master_clock_sel),
        .baud_exp(baud_exp), .decim_exp(decim_exp), .new_word_stb(new_word_stb), .sample_raw(sample_raw),
        .shift_clock_out(shift_clock_out), .serial_out_line(serial_out_line), .word_ready_n(word_ready_n),
        .cts_out(cts_out), .decimated_select_n(decimated_select_n), .chip_select_n(chip_select_n),
        .decim_flag(decim_flag), .cal_out(cal_out));

    remote_host_model remote_host_model_inst (.ref_clk(ref_clk), .shift_clock(remote_shift_clock_in),
        .select_n(remote_select_n), .cal_trigger(cal_trigger), .trim_a(trim_select_a), .trim_b(trim_select_b));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] code_of(input logic signed [17:0] r, input logic bip);
        int v;
        v = int'(r) + (bip ? 32768 : 0);
        if (v < 0) v = 0;
        if (v > 65535) v = 65535;
        return 16'(v);
    endfunction : code_of

    // Bit i of the result is the i-th bit on the line
    function automatic logic [21:0] frame_of(input logic [15:0] c, input logic am);
        logic [15:0] msb_first;
        msb_first = {<<{c}};
        return am ? {2'b11, c[7:0], 1'b0, 2'b11, c[15:8], 1'b0} : {6'h00, msb_first};
    endfunction : frame_of

    task automatic send_word(input logic signed [17:0] r, input logic note);
        @(negedge ref_clk);
        sample_raw = r;
        new_word_stb = 1'b1;
        if (note) expect_q.push_back(frame_of(code_of(r, input_polarity_sel), async_char_mode));
        @(negedge ref_clk);
        new_word_stb = 1'b0;
    endtask : send_word

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////
    // Frame watcher: collects bits while selected, compares with oldest note
    initial begin : watch_frames
        logic [21:0] cap;
        logic [21:0] exp_f;
        int nb;
        forever begin
            @(negedge word_ready_n);
            nb = async_char_mode ? 22 : 16;
            cap = '0;
            for (int i = 0; i < nb; i++) begin
                @(negedge shift_clock_out iff chip_select_n === 1'b0);
                cap[i] = serial_out_line;
            end
            @(posedge word_ready_n);
            exp_f = (expect_q.size() > 0) ? expect_q.pop_front() : ~cap;
            `CHK(cap, exp_f)
        end
    end

    initial begin
        #400000;
        num_errors++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {input_polarity_sel, decimator_route, board_baud_route, master_clock_sel, new_word_stb} = '0;
        {async_char_mode, ready_to_select_tie} = 2'b11;
        baud_exp = 4'h8;
        decim_exp = 4'h0;
        sample_raw = '0;
        repeat (6) @(negedge ref_clk);
        reset = 1'b0;
        repeat (6) @(negedge ref_clk);
        `CHK({shift_clock_out, serial_out_line, word_ready_n, cts_out, decimated_select_n, decim_flag}, 6'h1E)
        `CHK(cal_out, 3'h0)
        $display("reset values done");
        for (int n = 0; n < 2; n++) begin
            decim_exp = 4'(n);
            for (int w = 1; w <= (2 << n); w++) begin
                send_word(18'(w * 1000), 1'b1);
                repeat (6) @(negedge ref_clk);
                `CHK({decimated_select_n, decim_flag}, (w == (2 << n)) ? 2'h1 : 2'h2)
                decimator_route = 1'b1;
                @(negedge ref_clk);
                `CHK(chip_select_n, (w == (2 << n)) ? 1'b0 : 1'b1)
                decimator_route = (w == (2 << n));
                @(negedge ref_clk);
                `CHK({chip_select_n, cts_out}, 2'h0)
                remote_host_model_inst.frame(23, 1'b0);
                `CHK({decimated_select_n, decim_flag, word_ready_n}, 3'h5)
            end
        end
        decimator_route = 1'b0;
        $display("decimation done");
        for (int c = 0; c < 4; c++) begin
            pulses = 0;
            fork
                remote_host_model_inst.calibrate(c[1], c[0]);
                repeat (40) @(negedge ref_clk) if (cal_out.start === 1'b1) begin
                    pulses++;
                    kind = cal_out.kind;
                end
            join
            `CHK({2'(pulses), kind}, {2'h1, cal_kind[c]})
        end
        $display("calibration done");
        for (int k = 0; k < 8; k++) begin
            input_polarity_sel = k[0];
            remote_host_model_inst.calibrate(1'b0, 1'b0);
            raw = (k < 4) ? edge_raw[k] : 18'($random(seed));
            send_word(raw, 1'b1);
            if (k == 0) send_word(18'h00001, 1'b0);
            fork
                remote_host_model_inst.frame(23, 1'b0);
                if (k == 1) begin
                    repeat (100) @(negedge ref_clk);
                    send_word(18'h00155, 1'b0);
                end
            join
        end
        repeat (40) @(negedge ref_clk);
        `CHK(word_ready_n, 1'b1)
        $display("async frames done");
        {async_char_mode, ready_to_select_tie} = 2'b00;
        send_word(18'($random(seed)), 1'b1);
        remote_host_model_inst.frame(4, 1'b0);
        `CHK({word_ready_n, serial_out_line}, 2'h1)
        remote_host_model_inst.frame(17, 1'b1);
        `CHK(word_ready_n, 1'b1)
        $display("sync frame done");
        board_baud_route = 1'b1;
        for (int b = 0; b < 4; b++) begin
            @(negedge ref_clk);
            {master_clock_sel, baud_exp} = baud_cfg[b];
            repeat (2) @(posedge shift_clock_out);
            t0 = $realtime;
            @(posedge shift_clock_out);
            `CHK(int'($realtime - t0), baud_period[b])
        end
        $display("baud divider done");
        conclude();
    end
endmodule : adc_board_output_glue_test

/* File: adc_glue_pkg.sv */
// Shared constants and carrier types for the converter output glue logic
package adc_glue_pkg;

    // Character framing in asynchronous mode
    localparam int CHAR_START_BITS = 1;
    localparam int CHAR_DATA_BITS  = 8;
    localparam int CHAR_STOP_BITS  = 2;
    localparam int CHAR_BITS       = CHAR_START_BITS + CHAR_DATA_BITS + CHAR_STOP_BITS;
    localparam int WORD_CHARS      = 2;
    localparam int WORD_BITS       = 16;
    localparam int FRAME_BITS      = CHAR_BITS * WORD_CHARS;
    localparam logic [4:0] FRAME_LAST_ASYNC = 5'(FRAME_BITS - 1);
    localparam logic [4:0] FRAME_LAST_SYNC  = 5'(WORD_BITS - 1);

    // Baud divider: divide by 2**n, n in this range
    localparam int         DIV_CNT_BITS = 12;
    localparam logic [3:0] DIV_EXP_MIN  = 4'h8;
    localparam logic [3:0] DIV_EXP_MAX  = 4'hC;
    localparam int         OSC_FREQ_HZ  = 4915200;

    // Decimation counter: 2**(n+1) words, n in 0..11
    localparam int         DEC_CNT_BITS = 13;
    localparam logic [3:0] DEC_EXP_MAX  = 4'hB;

    // Output code limits
    localparam logic [15:0] CODE_ZERO     = 16'h0000;
    localparam logic [15:0] CODE_FULL     = 16'hFFFF;
    localparam logic [18:0] BIPOLAR_SHIFT = 19'h08000;

    // Synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 3;
    localparam int PIN_COUNT   = 7;

    typedef enum logic [1:0] {
        CAL_SELF,
        CAL_SYS_OFFSET_STEP1,
        CAL_SYS_GAIN_STEP2,
        CAL_SYS_OFFSET_ONE
    } cal_kind_e;

    typedef struct packed {
        logic      start;
        cal_kind_e kind;
    } cal_req_s;

endpackage : adc_glue_pkg

/* File: remote_host_model.sv */
// Remote controller model: shift clock, chip select and calibration controls
`timescale 1ns/1ps
module remote_host_model (
    input  wire logic ref_clk,
    output logic      shift_clock,
    output logic      select_n,
    output logic      cal_trigger,
    output logic      trim_a,
    output logic      trim_b
);
    initial begin
        shift_clock = 1'b0;
        select_n    = 1'b1;
        cal_trigger = 1'b0;
        trim_a      = 1'b0; // Local switches off, remote owns the levels
        trim_b      = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Clock only runs inside a frame and rests low between frames
    task automatic frame(input int pulses, input logic sel);
        @(negedge ref_clk) select_n = ~sel;
        repeat (6) @(negedge ref_clk);
        repeat (pulses) begin
            shift_clock = 1'b1;
            repeat (8) @(negedge ref_clk);
            shift_clock = 1'b0;
            repeat (8) @(negedge ref_clk);
        end
        select_n = 1'b1;
        repeat (4) @(negedge ref_clk);
    endtask : frame
    ////////////////////////////////////////////////////////////////////////////
    // Callers trigger after power-up and after every polarity change
    task automatic calibrate(input logic a, input logic b);
        @(negedge ref_clk);
        trim_a = a;
        trim_b = b;
        repeat (6) @(negedge ref_clk);
        cal_trigger = 1'b1;
        repeat (6) @(negedge ref_clk);
        cal_trigger = 1'b0;
    endtask : calibrate
endmodule : remote_host_model
